// file: inc/bldc_pkg.sv
// shared constants and types for the battery level detect control block
package bldc_pkg;
  localparam int ADDR_W = 12;
  // printed register indices; byte address is four times the index
  localparam logic [9:0] IDX_HL   = 10'h2e6;
  localparam logic [9:0] IDX_CTRL = 10'h2ff;
  localparam logic [9:0] IDX_IRQS = 10'h300;
  localparam logic [9:0] IDX_IRQC = 10'h301;
  localparam logic [9:0] IDX_IRQE = 10'h302;
  localparam logic [ADDR_W-1:0] ADDR_HL   = {IDX_HL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQS = {IDX_IRQS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQC = {IDX_IRQC, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQE = {IDX_IRQE, 2'b00};
  localparam int BIT_HL   = 3;
  localparam int BIT_FLAG = 3;
  localparam int IRQ_W    = 2;
  localparam int IRQ_LOAD = 0;
  localparam int IRQ_LOW  = 1;
  localparam logic [2:0] THR_RST = 3'h0;
  // detector settling time and clock rate
  localparam int SETTLE_NS   = 100000;
  localparam int CLK_MHZ     = 125;
  localparam int SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  typedef struct packed {
    logic       flag;
    logic [2:0] thr;
  } bldc_ctrl_t;
  typedef enum {HS_IDLE, HS_FIRST, HS_HOLD, HS_SAMPLE} bldc_hs_t;
endpackage : bldc_pkg

// file: design/bldc_sampler.sv
// heavy-load sampling sequencer: first window then 2 hz periodic windows
`timescale 1ns/1ps
module bldc_sampler
  import bldc_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYC
)(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic hl_mode_in,
  input  wire logic instr_end_in,
  input  wire logic tick_2hz_in,
  output logic      sample_on_out,
  output logic      strobe_out
);
  initial
  begin
    if (SETTLE < 1)
      $error("settle count must be at least one");
  end

  bldc_hs_t    state;
  logic        hl_prev;
  logic [31:0] cnt;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state         <= HS_IDLE;
      hl_prev       <= 1'b0;
      cnt           <= 32'h0;
      sample_on_out <= 1'b0;
      strobe_out    <= 1'b0;
    end
    else
    begin
      hl_prev    <= hl_mode_in;
      strobe_out <= 1'b0;
      case (state)
        HS_IDLE:
        begin
          if (hl_mode_in && !hl_prev)
          begin
            state         <= HS_FIRST;
            sample_on_out <= 1'b1;
          end
        end
        HS_FIRST:
        begin
          if (instr_end_in)
          begin
            state         <= HS_HOLD;
            sample_on_out <= 1'b0;
            strobe_out    <= 1'b1;
          end
        end
        HS_HOLD:
        begin
          if (tick_2hz_in)
          begin
            state         <= HS_SAMPLE;
            sample_on_out <= 1'b1;
            cnt           <= 32'h0;
          end
        end
        HS_SAMPLE:
        begin
          if (cnt == 32'(SETTLE - 1))
          begin
            state         <= HS_HOLD;
            sample_on_out <= 1'b0;
            strobe_out    <= 1'b1;
          end
          else
            cnt <= cnt + 32'h1;
        end
        default: state <= HS_IDLE;
      endcase
      // leaving heavy-load mode aborts any window without a latch
      if (!hl_mode_in)
      begin
        state         <= HS_IDLE;
        sample_on_out <= 1'b0;
        strobe_out    <= 1'b0;
      end
    end
  end

  // checks the window opens on mode entry
  property first_open_p;
    @(posedge clk_in) disable iff (!rst_n_in)
    (hl_mode_in && !hl_prev && state == HS_IDLE) |=> sample_on_out;
  endproperty
  first_window_a: assert property (first_open_p)
    else $error("first heavy-load window did not open");

endmodule : bldc_sampler

// file: design/bldc_ctrl.sv
// battery level detect control: apb registers, latch, heavy-load sampling
//
// Summary of operation
// - writing the heavy-load bit enters or leaves the mode; it reads back
// - heavy-load mode switches the detector on under sampling control
// - heavy-load samples: one instruction cycle after entry, then each 2 hz tick
// - heavy-load sample latched at end of each sampling window that closes while the mode is still set
// - writing control bit 3 switches detection on or off
// - reading control bit 3 returns the latched low-supply result
// - write meaning and read meaning of bit 3 are independent
// - clearing the enable bit loads the detector output into the latch
// - 3-bit threshold field selects one of eight detect levels
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module bldc_ctrl
  import bldc_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYC
)(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              detector_in,
  input  wire logic              instr_end_in,
  input  wire logic              tick_2hz_in,
  output logic                   detector_on_out,
  output logic [2:0]             threshold_out,
  output logic                   heavy_load_mode_out,
  output logic                   low_supply_flag_out,
  output logic                   irq_out
);
  initial
  begin
    if (SETTLE < 1)
      $error("settle count must be at least one");
  end

  logic             heavy_load_mode_bit;
  logic             detect_enable_bit;
  bldc_ctrl_t       ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic             det_s1;
  logic             det_s2;
  logic             det_s3;
  logic             det_level;
  logic             hl_on;
  logic             hl_strobe;

  // apb decode: setup phase prepares the answer, access phase completes it
  logic setup;
  logic access;
  logic wr_acc;
  logic hit_hl;
  logic hit_ctrl;
  logic hit_irqs;
  logic hit_irqc;
  logic hit_irqe;
  logic mapped;
  assign setup    = psel_in && !penable_in;
  assign access   = psel_in && penable_in && pready_out;
  assign wr_acc   = access && pwrite_in && !pslverr_out;
  assign hit_hl   = paddr_in == ADDR_HL;
  assign hit_ctrl = paddr_in == ADDR_CTRL;
  assign hit_irqs = paddr_in == ADDR_IRQS;
  assign hit_irqc = paddr_in == ADDR_IRQC;
  assign hit_irqe = paddr_in == ADDR_IRQE;
  assign mapped   = hit_hl || hit_ctrl || hit_irqs || hit_irqc || hit_irqe;

  logic bls_clear;
  logic load;
  logic [IRQ_W-1:0] events;
  assign bls_clear = wr_acc && hit_ctrl && !pwdata_in[BIT_FLAG] && detect_enable_bit;
  assign load      = bls_clear || hl_strobe;
  always_comb
  begin
    events           = '0;
    events[IRQ_LOAD] = load;
    events[IRQ_LOW]  = load && det_level;
  end

  // read mux, sampled into prdata during setup
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0;
    if (hit_hl)
      rd_word[BIT_HL] = heavy_load_mode_bit;
    else if (hit_ctrl)
      rd_word[3:0] = ctrl;
    else if (hit_irqs)
      rd_word[IRQ_W-1:0] = irq_status;
    else if (hit_irqe)
      rd_word[IRQ_W-1:0] = irq_enable;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end
    else if (setup)
    begin
      pready_out  <= 1'b1;
      pslverr_out <= !mapped;
      // read path shows latch, never enable
      prdata_out  <= (!pwrite_in && mapped) ? rd_word : 32'h0;
    end
    else
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // three-stage pin synchroniser; accept a change once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      det_s1    <= 1'b0;
      det_s2    <= 1'b0;
      det_s3    <= 1'b0;
      det_level <= 1'b0;
    end
    else
    begin
      det_s1 <= detector_in;
      det_s2 <= det_s1;
      det_s3 <= det_s2;
      if (det_s2 == det_s3)
        det_level <= det_s3;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      heavy_load_mode_bit <= 1'b0;
    else if (wr_acc && hit_hl)
      heavy_load_mode_bit <= pwdata_in[BIT_HL];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      detect_enable_bit <= 1'b0;
    else if (wr_acc && hit_ctrl)
      detect_enable_bit <= pwdata_in[BIT_FLAG];
  end

  // threshold and latch share one process: both live in the one ctrl struct
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl.thr  <= THR_RST;
      ctrl.flag <= 1'b0;
    end
    else
    begin
      if (wr_acc && hit_ctrl)
        ctrl.thr <= pwdata_in[2:0];
      if (load)
        ctrl.flag <= det_level;
    end
  end

  bldc_sampler #(
    .SETTLE (SETTLE)
  ) u_sampler (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .hl_mode_in    (heavy_load_mode_bit),
    .instr_end_in  (instr_end_in),
    .tick_2hz_in   (tick_2hz_in),
    .sample_on_out (hl_on),
    .strobe_out    (hl_strobe)
  );

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_status <= '0;
    else if (wr_acc && hit_irqc)
      irq_status <= (irq_status & ~pwdata_in[IRQ_W-1:0]) | events;
    else
      irq_status <= irq_status | events;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_enable <= '0;
    else if (wr_acc && hit_irqe)
      irq_enable <= pwdata_in[IRQ_W-1:0];
  end

  // outputs registered; they trail the internal state by one cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      detector_on_out     <= 1'b0;
      threshold_out       <= THR_RST;
      heavy_load_mode_out <= 1'b0;
      low_supply_flag_out <= 1'b0;
      irq_out             <= 1'b0;
    end
    else
    begin
      detector_on_out     <= detect_enable_bit || hl_on;
      threshold_out       <= ctrl.thr;
      heavy_load_mode_out <= heavy_load_mode_bit;
      low_supply_flag_out <= ctrl.flag;
      irq_out             <= |(irq_status & irq_enable);
    end
  end

  sequence wr_seq(logic [ADDR_W-1:0] a);
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == a;
  endsequence

  sequence rd_setup_seq(logic [ADDR_W-1:0] a);
    psel_in && !penable_in && !pwrite_in && paddr_in == a;
  endsequence

  hl_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_seq(ADDR_HL) |=> heavy_load_mode_bit == $past(pwdata_in[BIT_HL]))
    else $error("heavy-load bit did not take written value");

  hl_readback_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_setup_seq(ADDR_HL) |=> prdata_out[BIT_HL] == heavy_load_mode_bit)
    else $error("heavy-load bit read back wrong");

  hl_detector_on_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(heavy_load_mode_bit) |-> ##[2:3] detector_on_out)
    else $error("detector not on after heavy-load entry");

  hl_latch_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    hl_strobe |=> ctrl.flag == $past(det_level))
    else $error("heavy-load sample not latched");

  enable_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_seq(ADDR_CTRL) |=> detect_enable_bit == $past(pwdata_in[BIT_FLAG]) ##1
      detector_on_out || !detect_enable_bit)
    else $error("detection enable not applied");

  flag_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_setup_seq(ADDR_CTRL) |=> prdata_out[BIT_FLAG] == ctrl.flag)
    else $error("control read did not return latched result");

  write_no_flag_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_seq(ADDR_CTRL) ##0 (!detect_enable_bit && !hl_strobe) |=> $stable(ctrl.flag))
    else $error("write altered latched result");

  clear_load_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    bls_clear |=> ctrl.flag == $past(det_level))
    else $error("enable clear did not load latch");

  threshold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_seq(ADDR_CTRL) |=> ctrl.thr == $past(pwdata_in[2:0]) ##1
      threshold_out == $past(ctrl.thr))
    else $error("threshold field not written");

  latch_hold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !load |=> $stable(ctrl.flag))
    else $error("latch changed without load event");

  // heavy-load entry: mode rises, then the sampling window opens
  sequence hl_entry_seq;
    $rose(heavy_load_mode_bit) ##1 hl_on;
  endsequence

  hl_window_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    hl_entry_seq |=> detector_on_out)
    else $error("detector not powered during heavy-load window");

  hl_leave_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(heavy_load_mode_bit) |=> !hl_on && !hl_strobe)
    else $error("heavy-load window not closed on mode exit");

  window_latch_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ($fell(hl_on) && heavy_load_mode_bit) |-> hl_strobe)
    else $error("window closed without a latch strobe");

  flag_out_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $changed(ctrl.flag) |=> low_supply_flag_out == $past(ctrl.flag))
    else $error("flag output does not follow latch");

  status_set_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (events != '0) |=> (irq_status & $past(events)) == $past(events))
    else $error("load event lost against a status clear");

  irq_level_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ((irq_status & irq_enable) != '0) |=> irq_out)
    else $error("interrupt not raised for enabled status");

  ready_setup_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    setup |=> pready_out)
    else $error("no ready in access cycle");

  unmapped_err_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (setup && !mapped) |=> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped address not refused");

  det_filter_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $changed(det_level) |-> $past(det_s2) == $past(det_s3))
    else $error("detector level changed before stages agreed");

endmodule : bldc_ctrl

// file: verif/testbench.sv
// self-checking testbench for the battery level detect control block
`timescale 1ns/1ps
module testbench
  import bldc_pkg::*;
;
  // short settle window keeps the periodic heavy-load samples quick
  localparam int SET = 4;
  logic              clk_in = 1'b0;
  logic              rst_n_in, psel_in, penable_in, pwrite_in;
  logic [ADDR_W-1:0] paddr_in;
  logic [31:0]       pwdata_in, prdata_out, rd;
  logic              pready_out, pslverr_out, err;
  logic              detector_in, instr_end_in, tick_2hz_in;
  logic              detector_on_out, heavy_load_mode_out, low_supply_flag_out, irq_out;
  logic [2:0]        threshold_out;
  logic [15:0]       seed;
  int                bad_count, compares;
  int                m_flag, m_thr, m_stat;

  always #4 clk_in = ~clk_in;

  bldc_ctrl #(.SETTLE(SET)) u_dut (
    .clk_in              (clk_in),
    .rst_n_in            (rst_n_in),
    .psel_in             (psel_in),
    .penable_in          (penable_in),
    .pwrite_in           (pwrite_in),
    .paddr_in            (paddr_in),
    .pwdata_in           (pwdata_in),
    .prdata_out          (prdata_out),
    .pready_out          (pready_out),
    .pslverr_out         (pslverr_out),
    .detector_in         (detector_in),
    .instr_end_in        (instr_end_in),
    .tick_2hz_in         (tick_2hz_in),
    .detector_on_out     (detector_on_out),
    .threshold_out       (threshold_out),
    .heavy_load_mode_out (heavy_load_mode_out),
    .low_supply_flag_out (low_supply_flag_out),
    .irq_out             (irq_out)
  );

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      bad_count++;
      report_and_stop();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  // each pulse lowers only its own strobe, so back-to-back calls never collide
  task automatic pulse(input logic tick);
    if (tick)
    begin
      tick_2hz_in <= 1'b1;
      @(posedge clk_in);
      tick_2hz_in <= 1'b0;
    end
    else
    begin
      instr_end_in <= 1'b1;
      @(posedge clk_in);
      instr_end_in <= 1'b0;
    end
  endtask : pulse

  task automatic m_load(input int v);
    m_flag = v;
    m_stat = m_stat | 1 | (v << 1);
  endtask : m_load

  function automatic logic [31:0] ctrl_exp;
    return 32'(m_flag * 8 + m_thr);
  endfunction : ctrl_exp

  initial
  begin
    repeat (50000) @(posedge clk_in);
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {detector_in, instr_end_in, tick_2hz_in} = 3'h0;
    bad_count = 0;
    compares = 0;
    seed = 16'h5681;
    m_flag = 0;
    m_thr = 0;
    m_stat = 0;
    cyc(8);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("flag out", 32'h0, 32'(low_supply_flag_out));
    rchk("hl reg", ADDR_HL, 32'h0);
    rchk("ctrl reg", ADDR_CTRL, ctrl_exp());
    $display("test reset done");
    // enable stays off, so random detector levels must never reach the latch
    // detection kept off
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr_next(seed);
      detector_in <= seed[0];
      apb(1'b1, ADDR_CTRL, {seed, 12'h0, 1'b0, 3'(k)});
      m_thr = k;
      cyc(1);
      chk("threshold out", 32'(k), 32'(threshold_out));
      rchk("ctrl thr", ADDR_CTRL, ctrl_exp());
    end
    $display("test threshold done");
    for (int v = 1; v >= 0; v--)
    begin
      detector_in <= 1'(v);
      apb(1'b1, ADDR_CTRL, 32'(8 + m_thr));
      cyc(1);
      chk("det on", 32'h1, 32'(detector_on_out));
      rchk("ctrl enabled", ADDR_CTRL, ctrl_exp());
      cyc(SET + 8);
      apb(1'b1, ADDR_CTRL, 32'(m_thr));
      m_load(v);
      cyc(1);
      chk("det off", 32'h0, 32'(detector_on_out));
      rchk("ctrl loaded", ADDR_CTRL, ctrl_exp());
      detector_in <= 1'(1 - v);
      cyc(8);
      chk("flag held", 32'(m_flag), 32'(low_supply_flag_out));
    end
    $display("test enable done");
    rchk("irq status", ADDR_IRQS, 32'(m_stat));
    chk("irq off", 32'h0, 32'(irq_out));
    apb(1'b1, ADDR_IRQE, 32'h3);
    cyc(1);
    chk("irq on", 32'h1, 32'(irq_out));
    apb(1'b1, ADDR_IRQC, 32'h2);
    m_stat = m_stat & 1;
    rchk("irq clr", ADDR_IRQS, 32'(m_stat));
    rchk("irq clr reg", ADDR_IRQC, 32'h0);
    apb(1'b1, ADDR_IRQE, 32'h2);
    cyc(1);
    chk("irq masked", 32'h0, 32'(irq_out));
    apb(1'b1, ADDR_IRQC, 32'h3);
    m_stat = 0;
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk("unmapped err", 32'h1, 32'(err));
    rchk("ctrl after bad", ADDR_CTRL, ctrl_exp());
    $display("test irq done");
    // pulses outside heavy-load mode must not sample
    detector_in <= 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    cyc(SET + 8);
    rchk("no hl sample", ADDR_CTRL, ctrl_exp());
    apb(1'b1, ADDR_HL, 32'h8);
    cyc(3);
    chk("hl out", 32'h1, 32'(heavy_load_mode_out));
    chk("hl det on", 32'h1, 32'(detector_on_out));
    rchk("hl read", ADDR_HL, 32'h8);
    pulse(1'b0);
    m_load(1);
    cyc(3);
    rchk("first sample", ADDR_CTRL, ctrl_exp());
    chk("first window end", 32'h0, 32'(detector_on_out));
    for (int v = 0; v < 2; v++)
    begin
      detector_in <= 1'(v);
      cyc(8);
      pulse(1'b1);
      cyc(2);
      chk("tick window", 32'h1, 32'(detector_on_out));
      chk("flag before end", 32'(m_flag), 32'(low_supply_flag_out));
      cyc(SET + 5);
      m_load(v);
      chk("tick sample", 32'(m_flag), 32'(low_supply_flag_out));
    end
    apb(1'b1, ADDR_HL, 32'h0);
    cyc(1);
    chk("hl left", 32'h0, 32'(heavy_load_mode_out));
    rchk("hl read 0", ADDR_HL, 32'h0);
    rchk("hl irq", ADDR_IRQS, 32'(m_stat));
    $display("test heavy load done");
    report_and_stop();
  end
endmodule : testbench
